// ==== hdl/sensor_correction_config.sv ====
// Setup word loader, pin configuration and sensor correction datapath
`timescale 1ns/1ps
`default_nettype none
`include "scc_map.svh"
module sensor_correction_config #(
  parameter int LONG_WIN_US = `CMD_WIN_LONG_MS * 1000,
  parameter int SHORT_WIN_US = `CMD_WIN_SHORT_MS * 1000
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_leave_command_mode,
  output logic o_nvm_rd_req,
  output logic [7:0] o_nvm_addr,
  input wire logic i_nvm_rd_valid,
  input wire logic [15:0] i_nvm_rd_data,
  output logic [15:0] o_setup_word,
  output logic o_cfg_valid,
  output logic [6:0] o_bus_slave_address,
  output logic o_cmd_window_open,
  input wire logic i_low_trip,
  input wire logic i_high_trip,
  input wire logic i_ready,
  output logic o_low_trip_pin_out,
  output logic o_low_trip_pin_oe,
  output logic o_high_trip_pin_out,
  output logic o_high_trip_pin_oe,
  output logic o_ready_pin_out,
  output logic o_ready_pin_oe,
  input wire logic i_sclk,
  input wire logic i_miso_next,
  output logic o_miso,
  input wire logic i_start,
  input wire logic i_third_order,
  input wire logic [13:0] i_raw_cap,
  input wire logic [13:0] i_raw_temp,
  input wire logic [13:0] i_temp_ref,
  input wire logic [15:0] i_split_point,
  input wire logic signed [15:0] i_offset,
  input wire logic signed [15:0] i_gain1,
  input wire logic signed [15:0] i_gain2,
  input wire logic signed [15:0] i_region1_square_coef,
  input wire logic signed [15:0] i_region2_square_coef,
  input wire logic signed [15:0] i_tco,
  input wire logic signed [15:0] i_tcg,
  input wire logic signed [15:0] i_offset_drift_square,
  input wire logic signed [15:0] i_gain_drift_square,
  input wire logic signed [15:0] i_gain_t,
  input wire logic signed [15:0] i_offset_t,
  input wire logic signed [15:0] i_temperature_square_coef,
  output logic o_busy,
  output logic o_done,
  output logic signed [15:0] o_cap_corrected,
  output logic signed [15:0] o_temp_corrected
);
  localparam int F = `FRAC_BITS;

  function automatic logic signed [15:0] sat16(input logic signed [95:0] v);
    if (v > 96'sd32767) begin
      sat16 = 16'sh7fff;
    end else if (v < -96'sd32768) begin
      sat16 = -16'sh8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction : sat16

  // ==========================================================
  // Setup word loading
  // ==========================================================
  scc_pkg::cfg_state_e cfg_state_reg;
  logic [15:0] cfg_reg;
  logic first_load_reg;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_state_reg <= scc_pkg::CFG_REQ;
    end else begin
      unique case (cfg_state_reg)
        scc_pkg::CFG_IDLE: begin
          if (i_leave_command_mode) begin
            cfg_state_reg <= scc_pkg::CFG_REQ;
          end
        end
        scc_pkg::CFG_REQ: begin
          if (i_nvm_rd_valid) begin
            cfg_state_reg <= scc_pkg::CFG_DONE;
          end
        end
        scc_pkg::CFG_DONE: begin
          cfg_state_reg <= scc_pkg::CFG_IDLE;
        end
        default: begin
          cfg_state_reg <= scc_pkg::CFG_IDLE;
        end
      endcase
    end
  end

  // Bits 15:14 are stored as read; the host keeps them at factory values
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_reg <= `CFG_RESET;
    end else if (cfg_state_reg == scc_pkg::CFG_REQ && i_nvm_rd_valid) begin
      cfg_reg <= i_nvm_rd_data;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      first_load_reg <= 1'b1;
    end else if (cfg_state_reg == scc_pkg::CFG_DONE) begin
      first_load_reg <= 1'b0;
    end
  end

  assign o_nvm_rd_req = (cfg_state_reg == scc_pkg::CFG_REQ);
  assign o_nvm_addr = `CFG_WORD_ADDR;
  assign o_setup_word = cfg_reg;
  assign o_cfg_valid = (cfg_state_reg == scc_pkg::CFG_IDLE);
  assign o_bus_slave_address = cfg_reg[`ADDR_MSB:0];

  // ==========================================================
  // Startup command window
  // ==========================================================
  logic [7:0] us_div_reg;
  logic us_tick;
  logic [15:0] win_us_reg;
  logic win_open_reg;
  logic [15:0] win_limit;

  assign us_tick = (us_div_reg == 8'(`US_TICK_CYCLES - 1));
  assign win_limit = cfg_reg[`FAST_START_BIT] ? 16'(SHORT_WIN_US)
                                              : 16'(LONG_WIN_US);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      us_div_reg <= 8'h00;
    end else if (!win_open_reg || us_tick) begin
      us_div_reg <= 8'h00;
    end else begin
      us_div_reg <= us_div_reg + 8'h01;
    end
  end

  // Window opens only after the power-on load, not after later reloads
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      win_open_reg <= 1'b0;
      win_us_reg <= 16'h0000;
    end else if (cfg_state_reg == scc_pkg::CFG_DONE && first_load_reg) begin
      win_open_reg <= 1'b1;
      win_us_reg <= 16'h0000;
    end else if (win_open_reg && us_tick) begin
      win_us_reg <= win_us_reg + 16'h0001;
      if (win_us_reg == win_limit - 16'h0001) begin
        win_open_reg <= 1'b0;
      end
    end
  end

  assign o_cmd_window_open = win_open_reg;

  // ==========================================================
  // Pin drivers
  // ==========================================================
  pin_driver u_low_trip (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_active(i_low_trip),
    .i_active_low(cfg_reg[`LOW_POL_BIT]),
    .i_open_drain(cfg_reg[`LOW_OD_BIT]),
    .o_pin_out(o_low_trip_pin_out),
    .o_pin_oe(o_low_trip_pin_oe)
  );

  pin_driver u_high_trip (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_active(i_high_trip),
    .i_active_low(cfg_reg[`HIGH_POL_BIT]),
    .i_open_drain(cfg_reg[`HIGH_OD_BIT]),
    .o_pin_out(o_high_trip_pin_out),
    .o_pin_oe(o_high_trip_pin_oe)
  );

  pin_driver u_ready (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_active(i_ready),
    .i_active_low(1'b0),
    .i_open_drain(cfg_reg[`READY_OD_BIT]),
    .o_pin_out(o_ready_pin_out),
    .o_pin_oe(o_ready_pin_oe)
  );

  // ==========================================================
  // Serial data launch edge
  // ==========================================================
  logic sclk_prev_reg;
  logic launch;

  // Launch on the edge opposite to the master's sampling edge
  assign launch = cfg_reg[`SPI_PHASE_BIT] ? (i_sclk && !sclk_prev_reg)
                                          : (!i_sclk && sclk_prev_reg);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_prev_reg <= 1'b0;
      o_miso <= 1'b0;
    end else begin
      sclk_prev_reg <= i_sclk;
      if (launch) begin
        o_miso <= i_miso_next;
      end
    end
  end

  // ==========================================================
  // Correction datapath
  // ==========================================================
  scc_pkg::calc_state_e calc_state_reg;
  logic [5:0] step_reg;
  logic signed [15:0] dt;
  logic signed [31:0] x_term, tco_eff, tcg_eff, num, den;
  logic signed [47:0] odrift, gdrift;
  logic [47:0] dvd_reg;
  logic [32:0] rem_reg;
  logic [31:0] den_reg;
  logic neg_reg;
  logic [32:0] rem_sh;
  logic signed [31:0] raw_tc, split, r1, r2, diff;
  logic signed [47:0] g1r1, g2r2;
  logic signed [95:0] poly;
  logic signed [95:0] g1w, g2w, sq1w, sq2w;
  logic signed [15:0] rt;
  logic signed [63:0] temp_full;

  assign dt = $signed({2'b00, i_raw_temp}) - $signed({2'b00, i_temp_ref});
  // Offset is referenced to half of full scale
  assign x_term = $signed({18'd0, i_raw_cap}) - `MID_SCALE
                + 32'(i_offset);
  // Drift coefficients assumed bounded so the divisor stays positive
  assign tco_eff = 32'(i_tco)
                 + ((32'(dt) * 32'(i_offset_drift_square)) >>> F);
  assign tcg_eff = 32'(i_tcg)
                 + ((32'(dt) * 32'(i_gain_drift_square)) >>> F);
  assign odrift = (48'(dt) * 48'(tco_eff)) >>> F;
  assign gdrift = (48'(dt) * 48'(tcg_eff)) >>> F;
  assign num = x_term + 32'(odrift);
  assign den = (32'sd1 <<< F) + 32'(gdrift);
  assign rem_sh = {rem_reg[31:0], dvd_reg[47]};

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      calc_state_reg <= scc_pkg::CALC_IDLE;
      step_reg <= 6'h00;
    end else begin
      unique case (calc_state_reg)
        scc_pkg::CALC_IDLE: begin
          if (i_start) begin
            calc_state_reg <= scc_pkg::CALC_PREP;
          end
        end
        scc_pkg::CALC_PREP: begin
          calc_state_reg <= scc_pkg::CALC_DIV;
          step_reg <= 6'h00;
        end
        scc_pkg::CALC_DIV: begin
          step_reg <= step_reg + 6'h01;
          if (step_reg == 6'(`DIV_STEPS - 1)) begin
            calc_state_reg <= scc_pkg::CALC_POLY;
          end
        end
        scc_pkg::CALC_POLY: begin
          calc_state_reg <= scc_pkg::CALC_IDLE;
        end
      endcase
    end
  end

  // Restoring divider on magnitudes; the sign is restored afterwards
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      dvd_reg <= 48'h0;
      rem_reg <= 33'h0;
      den_reg <= 32'h1;
      neg_reg <= 1'b0;
    end else if (calc_state_reg == scc_pkg::CALC_PREP) begin
      dvd_reg <= {16'h0, (num < 0) ? 32'(-num) : 32'(num)} << F;
      rem_reg <= 33'h0;
      den_reg <= (den > 0) ? 32'(den) : 32'h1;
      neg_reg <= (num < 0);
    end else if (calc_state_reg == scc_pkg::CALC_DIV) begin
      if (rem_sh >= {1'b0, den_reg}) begin
        rem_reg <= rem_sh - {1'b0, den_reg};
        dvd_reg <= {dvd_reg[46:0], 1'b1};
      end else begin
        rem_reg <= rem_sh;
        dvd_reg <= {dvd_reg[46:0], 1'b0};
      end
    end
  end

  assign raw_tc = neg_reg ? -$signed(dvd_reg[31:0]) : $signed(dvd_reg[31:0]);
  assign split = $signed({16'h0, i_split_point});
  assign diff = raw_tc - split;
  assign r1 = (raw_tc < split) ? raw_tc : split;
  assign r2 = (diff > 0) ? diff : 32'sd0;
  assign g1r1 = (48'(i_gain1) * 48'(i_third_order ? raw_tc : r1)) >>> F;
  assign g2r2 = (48'(i_gain2) * 48'(r2)) >>> F;
  assign g1w = 96'(g1r1);
  assign g2w = 96'(g2r2);
  assign sq1w = 96'(i_region1_square_coef);
  assign sq2w = 96'(i_region2_square_coef);

  always_comb begin
    if (i_third_order) begin
      // Region-two square coefficient doubles as the cube coefficient
      poly = ((sq2w * g1w * g1w * g1w) >>> (3 * F))
           + ((sq1w * g1w * g1w) >>> (2 * F))
           + g1w;
    end else begin
      poly = ((sq1w * g1w * g1w) >>> (2 * F)) + g1w
           + ((sq2w * g2w * g2w) >>> (2 * F))
           + g2w;
    end
  end

  // Raw temperature is 14 bits wide, so it is always within 0..16383
  assign rt = $signed({2'b00, i_raw_temp});
  assign temp_full = ((64'(i_gain_t) * 64'(rt)) >>> F) + 64'(i_offset_t)
                   + ((64'(i_temperature_square_coef) * 64'(rt) * 64'(rt))
                      >>> (2 * F));

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cap_corrected <= 16'sh0000;
      o_temp_corrected <= 16'sh0000;
      o_done <= 1'b0;
    end else begin
      o_done <= (calc_state_reg == scc_pkg::CALC_POLY);
      if (calc_state_reg == scc_pkg::CALC_POLY) begin
        o_cap_corrected <= sat16(poly);
        o_temp_corrected <= sat16(96'(temp_full));
      end
    end
  end

  assign o_busy = (calc_state_reg != scc_pkg::CALC_IDLE);

  // ==========================================================
  // Checks
  // ==========================================================
  localparam int DONE_MAX = 60;

  chk_reload_request: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (cfg_state_reg == scc_pkg::CFG_IDLE && i_leave_command_mode)
    |=> o_nvm_rd_req)
    else $error("Reload not requested after leaving command mode");
  chk_address_field: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (o_nvm_rd_req && i_nvm_rd_valid)
    |=> o_bus_slave_address == $past(i_nvm_rd_data[6:0]))
    else $error("Slave address not taken from loaded word");
  chk_low_pushpull: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (!cfg_reg[`LOW_OD_BIT] && $stable(cfg_reg)) |=> (o_low_trip_pin_oe
    && o_low_trip_pin_out == $past(i_low_trip ^ cfg_reg[`LOW_POL_BIT])))
    else $error("Low trip pin level wrong");
  chk_high_drain: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (cfg_reg[`HIGH_OD_BIT] && $stable(cfg_reg)) |=> (!o_high_trip_pin_out
    && o_high_trip_pin_oe == $past(i_high_trip ~^ cfg_reg[`HIGH_POL_BIT])))
    else $error("High trip open drain wrong");
  chk_miso_launch: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (!cfg_reg[`SPI_PHASE_BIT] && $fell(i_sclk))
    |=> o_miso == $past(i_miso_next))
    else $error("MISO not launched on falling edge");
  chk_ready_drain: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (cfg_reg[`READY_OD_BIT] && $stable(cfg_reg)) |=> !o_ready_pin_out)
    else $error("Ready pin drove high in open drain");
  chk_window_limit: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    o_cmd_window_open |-> win_us_reg < win_limit)
    else $error("Command window overran its length");
  chk_calc_latency: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    $rose(o_busy) |-> ##[1:DONE_MAX] o_done)
    else $error("Correction did not finish in time");
  chk_temp_zero: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (calc_state_reg == scc_pkg::CALC_POLY && i_gain_t == 0
     && i_temperature_square_coef == 0)
    |=> o_temp_corrected == $past(i_offset_t))
    else $error("Temperature offset not applied");

  cov_reload: cover property (@(posedge i_core_clk) disable iff (i_rst)
    i_leave_command_mode ##[1:8] o_cfg_valid);
  cov_third_order: cover property (@(posedge i_core_clk) disable iff (i_rst)
    o_done && i_third_order);
  cov_two_region: cover property (@(posedge i_core_clk) disable iff (i_rst)
    o_done && !i_third_order && r2 > 0);
endmodule : sensor_correction_config
`default_nettype wire

// ==== hdl/scc_map.svh ====
// Constants of the capacitive sensor correction and configuration core
// Functional notes
// - Reload setup word from storage at power-on and on leave_command_mode.
// - Bit 7 low-trip polarity (1 active low); bit 8 open-drain driver.
// - Bit 9 high-trip polarity (1 active low); bit 10 open-drain driver.
// - Bit 11: master samples MISO on rising (0) or falling (1) edge.
// - Bit 13 sets the startup command window: 10ms (0) or 3ms (1).
// - Datapath selects two-region second order or single-region third order.
// - Corrected raw = (raw+offset+dT*(tco+dT*sq))/(1+dT*(tcg+dT*sq)).
// - Region one input is min(raw, split); region two max(0, raw-split).
// - Two-region output sums square and linear terms of each region.
// - Third order reuses region-two square coefficient as cube coefficient.
// - Sensor offset is applied relative to mid-scale input.
// - Temperature corrected with gain, offset and second-order terms.
// - Temperature gain, offset and second-order coefficients are signed 16-bit.
// - Raw temperature accepted in 0..16383; result is signed 16-bit.
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH

`define CFG_WORD_ADDR 8'h1c
`define CFG_RESET 16'h0028
`define ADDR_MSB 6
`define LOW_POL_BIT 7
`define LOW_OD_BIT 8
`define HIGH_POL_BIT 9
`define HIGH_OD_BIT 10
`define SPI_PHASE_BIT 11
`define READY_OD_BIT 12
`define FAST_START_BIT 13

`define CLK_FREQ_MHZ 200
`define US_TICK_CYCLES (`CLK_FREQ_MHZ)
`define CMD_WIN_LONG_MS 10
`define CMD_WIN_SHORT_MS 3

`define FRAC_BITS 14
`define RAW_FULL_SCALE 32'sd16384
`define MID_SCALE (`RAW_FULL_SCALE / 2)
`define DIV_STEPS 48

`endif

// ==== hdl/scc_pkg.sv ====
// Types shared by the correction and configuration core
package scc_pkg;
  typedef enum logic [1:0] {
    CFG_IDLE = 2'b00,
    CFG_REQ = 2'b01,
    CFG_DONE = 2'b10
  } cfg_state_e;

  typedef enum logic [1:0] {
    CALC_IDLE = 2'b00,
    CALC_PREP = 2'b01,
    CALC_DIV = 2'b10,
    CALC_POLY = 2'b11
  } calc_state_e;

  typedef logic signed [15:0] coef_t;
endpackage : scc_pkg

// ==== hdl/pin_driver.sv ====
// Registered output pin with selectable polarity and push-pull/open-drain
`timescale 1ns/1ps
`default_nettype none
module pin_driver (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_active,
  input wire logic i_active_low,
  input wire logic i_open_drain,
  output logic o_pin_out,
  output logic o_pin_oe
);
  logic level;

  assign level = i_active ^ i_active_low;

  // Open drain only ever pulls low; released level comes from the pull-up
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pin_out <= 1'b0;
      o_pin_oe <= 1'b0;
    end else if (i_open_drain) begin
      o_pin_out <= 1'b0;
      o_pin_oe <= ~level;
    end else begin
      o_pin_out <= level;
      o_pin_oe <= 1'b1;
    end
  end
endmodule : pin_driver
`default_nettype wire

// ==== verification/nvm_model.sv ====
// Storage model that answers setup word reads after a settable delay
`timescale 1ns/1ps
`default_nettype none
module nvm_model (
  input wire logic i_core_clk,
  input wire logic i_rd_req,
  input wire logic [7:0] i_addr,
  input wire logic [3:0] i_delay,
  input wire logic [15:0] i_word,
  output logic o_rd_valid,
  output logic [15:0] o_rd_data
);
  logic [3:0] wait_cnt = 4'h0;
  initial o_rd_valid = 1'b0;
  // Outside the answer cycle the data bus is not driven: show a moving pattern
  assign o_rd_data = o_rd_valid ? i_word : ~i_word ^ {12'h000, wait_cnt};
  always @(negedge i_core_clk) begin
    o_rd_valid <= 1'b0;
    if (i_rd_req && !o_rd_valid && i_addr == 8'h1c) begin
      if (wait_cnt >= i_delay) begin
        o_rd_valid <= 1'b1;
        wait_cnt <= 4'h0;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule : nvm_model
`default_nettype wire

// ==== verification/sensor_correction_config_tb.sv ====
// Self-checking bench for setup word, pins, serial phase and correction
`timescale 1ns/1ps
`default_nettype none
`include "scc_map.svh"
module sensor_correction_config_tb;
  // ==========================================================
  // Signals
  typedef struct {longint cap; longint temp; int at;} note_s;
  note_s notes[$];
  note_s note;
  int errors = 0, checked = 0, cyc = 0, done_cnt = 0;
  logic [15:0] lfsr = 16'h0033, word = 16'h0000;
  logic [3:0] delay = 4'h0;
  logic i_core_clk = 1'b0, i_rst = 1'b1, i_leave_command_mode = 1'b0;
  logic i_low_trip = 1'b0, i_high_trip = 1'b0, i_ready = 1'b0;
  logic i_sclk = 1'b0, i_miso_next = 1'b0, i_start = 1'b0, i_third_order;
  logic i_nvm_rd_valid, o_nvm_rd_req, o_cfg_valid, o_cmd_window_open, o_miso;
  logic o_low_trip_pin_out, o_low_trip_pin_oe, o_high_trip_pin_out;
  logic o_high_trip_pin_oe, o_ready_pin_out, o_ready_pin_oe, o_busy, o_done;
  logic [6:0] o_bus_slave_address;
  logic [7:0] o_nvm_addr;
  logic [13:0] i_raw_cap, i_raw_temp, i_temp_ref;
  logic [15:0] i_nvm_rd_data, o_setup_word, i_split_point;
  logic signed [15:0] i_offset, i_gain1, i_gain2, i_region1_square_coef;
  logic signed [15:0] i_region2_square_coef, i_tco, i_tcg, i_gain_t;
  logic signed [15:0] i_offset_t, i_offset_drift_square, i_gain_drift_square;
  logic signed [15:0] i_temperature_square_coef;
  logic signed [15:0] o_cap_corrected, o_temp_corrected;

  // Short window parameters keep the run brief: 3 us and 1 us
  sensor_correction_config #(.LONG_WIN_US(3), .SHORT_WIN_US(1))
    i_dut (.i_core_clk, .i_rst, .i_leave_command_mode, .o_nvm_rd_req,
    .o_nvm_addr, .i_nvm_rd_valid, .i_nvm_rd_data, .o_setup_word, .o_cfg_valid,
    .o_bus_slave_address, .o_cmd_window_open, .i_low_trip, .i_high_trip,
    .i_ready, .o_low_trip_pin_out, .o_low_trip_pin_oe, .o_high_trip_pin_out,
    .o_high_trip_pin_oe, .o_ready_pin_out, .o_ready_pin_oe, .i_sclk,
    .i_miso_next, .o_miso, .i_start, .i_third_order, .i_raw_cap, .i_raw_temp,
    .i_temp_ref, .i_split_point, .i_offset, .i_gain1, .i_gain2,
    .i_region1_square_coef, .i_region2_square_coef, .i_tco, .i_tcg,
    .i_offset_drift_square, .i_gain_drift_square, .i_gain_t, .i_offset_t,
    .i_temperature_square_coef, .o_busy, .o_done, .o_cap_corrected,
    .o_temp_corrected);
  nvm_model i_nvm (.i_core_clk, .i_rd_req(o_nvm_rd_req), .i_addr(o_nvm_addr),
    .i_delay(delay), .i_word(word), .o_rd_valid(i_nvm_rd_valid),
    .o_rd_data(i_nvm_rd_data));

  always #2.5 i_core_clk = ~i_core_clk;

  // ==========================================================
  // Helpers
  task automatic results();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      errors++;
      results();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask : tick
  function automatic logic [15:0] rnd();
    for (int k = 0; k < 16; k++)
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd
  function automatic logic signed [15:0] sx(input int n);
    logic signed [15:0] v;
    v = rnd();
    return (v <<< (16 - n)) >>> (16 - n);
  endfunction : sx
  function automatic longint sat(input longint v);
    return v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
  endfunction : sat

  // ==========================================================
  // Setup word and pins
  task automatic wait_cfg(input logic [15:0] w);
    for (int n = 0; n < 40 && o_cfg_valid !== 1'b1; n++) tick(1);
    tick(1);
    check(o_setup_word, w);
    check(o_bus_slave_address, w[6:0]);
  endtask : wait_cfg
  task automatic window_check(input logic [15:0] w, input int us);
    word = w;
    i_rst = 1'b1;
    tick(8);
    check(o_setup_word, 16'h0028);
    check(o_nvm_addr, 8'h1c);
    i_rst = 1'b0;
    wait_cfg(w);
    tick(4);
    check(o_cmd_window_open, 1'b1);
    tick(us * `US_TICK_CYCLES - 15);
    check(o_cmd_window_open, 1'b1);
    tick(20);
    check(o_cmd_window_open, 1'b0);
    $display("window test done");
  endtask : window_check
  task automatic pin(input logic o, oe, act, pol, od);
    check(od ? oe : o, od ? !(act ^ pol) : act ^ pol);
    check(od ? o : oe, od ? 1'b0 : 1'b1);
  endtask : pin
  task automatic spi_case(input logic p);
    logic b;
    b = ~o_miso;
    i_sclk = ~p;
    tick(4);
    i_miso_next = b;
    tick(1);
    i_sclk = p;
    tick(4);
    check(o_miso, b);
    i_miso_next = ~b;
    tick(1);
    i_sclk = ~p;
    tick(4);
    check(o_miso, b);
  endtask : spi_case
  task automatic pin_case(input logic [3:0] k);
    logic [15:0] r;
    r = rnd();
    word = {2'b00, r[13], k[0] ^ k[1], k[2], k, r[6:0]};
    delay = k;
    i_leave_command_mode = 1'b1;
    tick(1);
    i_leave_command_mode = 1'b0;
    wait_cfg(word);
    for (int a = 0; a < 2; a++) begin
      i_low_trip = a[0];
      i_high_trip = !a[0];
      i_ready = a[0];
      tick(3);
      pin(o_low_trip_pin_out, o_low_trip_pin_oe, a[0], word[7], word[8]);
      pin(o_high_trip_pin_out, o_high_trip_pin_oe, !a[0], word[9], word[10]);
      pin(o_ready_pin_out, o_ready_pin_oe, a[0], 1'b0, word[12]);
    end
    spi_case(word[11]);
  endtask : pin_case

  // ==========================================================
  // Correction datapath
  task automatic rand_calc(input logic mode);
    i_third_order = mode;
    i_raw_cap = 14'(rnd());
    i_offset = sx(11);
    i_raw_temp = 14'h1000 + 14'(rnd() & 16'h0fff);
    i_temp_ref = 14'h1700 + 14'(rnd() & 16'h03ff);
    i_tco = sx(10);
    i_tcg = sx(10);
    i_offset_drift_square = sx(7);
    i_gain_drift_square = sx(7);
    i_gain1 = 16'h3000 + (rnd() & 16'h1fff);
    i_gain2 = 16'h3000 + (rnd() & 16'h1fff);
    i_region1_square_coef = sx(13);
    i_region2_square_coef = sx(13);
    i_split_point = rnd() & 16'h1fff;
    i_gain_t = rnd();
    i_offset_t = rnd();
    i_temperature_square_coef = rnd();
  endtask : rand_calc
  function automatic longint exp_cap();
    longint dt, x, num, den, tc, sp, r1, r2, g1, g2, sq1, sq2;
    dt = longint'(i_raw_temp) - longint'(i_temp_ref);
    x = longint'(i_raw_cap) - 8192 + i_offset;
    num = x + ((dt * (i_tco + ((dt * i_offset_drift_square) >>> 14))) >>> 14);
    den = 16384 + ((dt * (i_tcg + ((dt * i_gain_drift_square) >>> 14))) >>> 14);
    if (den <= 0) den = 1;
    tc = (num * 16384) / den;
    sp = longint'(i_split_point);
    sq1 = i_region1_square_coef;
    sq2 = i_region2_square_coef;
    if (i_third_order) begin
      g1 = (i_gain1 * tc) >>> 14;
      return sat(((sq2 * g1 * g1 * g1) >>> 42) + ((sq1 * g1 * g1) >>> 28) + g1);
    end
    r1 = tc < sp ? tc : sp;
    r2 = tc - sp > 0 ? tc - sp : 0;
    g1 = (i_gain1 * r1) >>> 14;
    g2 = (i_gain2 * r2) >>> 14;
    return sat(((sq1 * g1 * g1) >>> 28) + g1 + ((sq2 * g2 * g2) >>> 28) + g2);
  endfunction : exp_cap
  function automatic longint exp_temp();
    longint t;
    t = longint'(i_raw_temp);
    return sat(((i_gain_t * t) >>> 14) + i_offset_t +
      ((i_temperature_square_coef * t * t) >>> 28));
  endfunction : exp_temp
  task automatic run_calc(input logic mode, input logic poke);
    int m;
    m = done_cnt;
    rand_calc(mode);
    // Zero gain and square terms leave only the temperature offset
    if (poke) begin
      i_gain_t = 16'sh0000;
      i_temperature_square_coef = 16'sh0000;
    end
    i_start = 1'b1;
    notes.push_back('{exp_cap(), exp_temp(), cyc});
    tick(1);
    i_start = 1'b0;
    check(o_busy, 1'b1);
    // A start while busy must be refused and produce no extra result
    if (poke) begin
      tick(10);
      i_start = 1'b1;
      tick(1);
      i_start = 1'b0;
    end
    for (int n = 0; n < 80 && done_cnt == m; n++) tick(1);
  endtask : run_calc
  always @(negedge i_core_clk) begin
    if (o_done === 1'b1) begin
      done_cnt++;
      if (notes.size() == 0) begin
        check(o_done, 1'b0);
      end else begin
        note = notes.pop_front();
        check(o_cap_corrected, 16'(note.cap));
        check(o_temp_corrected, 16'(note.temp));
        check(cyc - note.at, 51);
      end
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    rand_calc(1'b0);
    window_check(16'h2028, 1);
    window_check(16'h0155, 3);
    for (int k = 0; k < 16; k++) pin_case(4'(k));
    check(o_cmd_window_open, 1'b0);
    $display("pin and serial test done");
    for (int k = 0; k < 10; k++) run_calc(k[0], k == 3);
    tick(60);
    check(notes.size(), 0);
    $display("correction test done");
    results();
  end
endmodule : sensor_correction_config_tb
`default_nettype wire
